// File: rtl/acsf_conv_slice.sv
`timescale 1ns/100ps
module acsf_conv_slice #(
  parameter int RES_W = 24,
  parameter int COEF_W = 24,
  parameter logic [COEF_W-1:0] OFS_RST = '0,
  parameter logic [COEF_W-1:0] GN_RST = '0
) (
  input wire logic sys_clk,
  input wire logic rst,
  acsf_conv_if.conv ctl,
  input wire logic res_valid,
  input wire logic [RES_W-1:0] res_data,
  input wire logic res_clamped,
  input wire logic cal_done,
  input wire logic cal_ok,
  input wire logic cal_is_gain,
  input wire logic [COEF_W-1:0] cal_coef,
  input wire logic cal_block,
  output logic [RES_W-1:0] result_ff,
  output logic [COEF_W-1:0] offset_ff,
  output logic [COEF_W-1:0] gain_ff
);
  logic ready_ff, err_ff, cal_hit_ff;
  logic nxt_ready, nxt_err, nxt_cal_hit;
  logic [RES_W-1:0] nxt_result;
  logic [COEF_W-1:0] nxt_offset, nxt_gain;
  logic accept, cal_ev;
  always_comb begin
    cal_ev = cal_done && !cal_block;
    accept = !ready_ff;
    nxt_result = result_ff;
    nxt_offset = offset_ff;
    nxt_gain = gain_ff;
    nxt_cal_hit = accept && cal_ev;
    // a finishing operation is taken only while ready is clear; one arriving while ready is set is dropped
    nxt_ready = (ready_ff && !(ctl.start || ctl.rdy_clr)) ||
                (accept && (res_valid || cal_ev));
    nxt_err = (err_ff && !ctl.start) ||
              (accept && res_valid && (res_clamped || ctl.missing_ref)) ||
              (accept && cal_ev && !cal_ok);
    if (accept && res_valid) begin
      nxt_result = ctl.missing_ref ? '1 : res_data;
    end
    if (accept && cal_ev && cal_ok) begin
      if (cal_is_gain) begin
        nxt_gain = cal_coef;
      end else begin
        nxt_offset = cal_coef;
      end
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ready_ff <= 1'b0;
      err_ff <= 1'b0;
      cal_hit_ff <= 1'b0;
      result_ff <= '0;
      offset_ff <= OFS_RST;
      gain_ff <= GN_RST;
    end else begin
      ready_ff <= nxt_ready;
      err_ff <= nxt_err;
      cal_hit_ff <= nxt_cal_hit;
      result_ff <= nxt_result;
      offset_ff <= nxt_offset;
      gain_ff <= nxt_gain;
    end
  end
  assign ctl.ready = ready_ff;
  assign ctl.err = err_ff;
  assign ctl.cal_hit = cal_hit_ff;
endmodule

// File: rtl/acsf_status_top.sv
`timescale 1ns/100ps
module acsf_status_top #(
  parameter int P_RES_W = 24,
  parameter int A_RES_W = 24,
  parameter int P_COEF_W = 24,
  parameter int A_COEF_W = 16,
  parameter logic [7:0] DECIM_INIT = acsf_pkg::DECIM_RST
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire acsf_pkg::acsf_byte_t sfr_wdata,
  output acsf_pkg::acsf_byte_t sfr_rdata_ff,
  input wire logic [7:0] bit_addr,
  input wire logic bit_wr,
  input wire logic bit_rd,
  input wire logic bit_wdata,
  output logic bit_rdata_ff,
  input wire logic vref_bad_pin,
  input wire logic p_res_valid,
  input wire logic [P_RES_W-1:0] p_res_data,
  input wire logic p_res_clamped,
  input wire logic p_cal_done,
  input wire logic p_cal_ok,
  input wire logic p_cal_is_gain,
  input wire logic [P_COEF_W-1:0] p_cal_coef,
  input wire logic a_res_valid,
  input wire logic [A_RES_W-1:0] a_res_data,
  input wire logic a_res_clamped,
  input wire logic a_cal_done,
  input wire logic a_cal_ok,
  input wire logic a_cal_is_gain,
  input wire logic [A_COEF_W-1:0] a_cal_coef,
  input wire logic a_temp_sel,
  output acsf_pkg::acsf_byte_t mode_ff,
  output acsf_pkg::acsf_byte_t decim_ff,
  output logic p_start_ff,
  output logic a_start_ff
);
  import acsf_pkg::*;

  // ****************************************
  // sub-blocks
  // ****************************************
  acsf_conv_if p_if();
  acsf_conv_if a_if();
  logic vref_bad_sync;
  logic [P_RES_W-1:0] p_result;
  logic [P_COEF_W-1:0] p_offset, p_gain;
  logic [A_RES_W-1:0] a_result;
  logic [A_COEF_W-1:0] a_offset, a_gain;

  // the missing-reference pin is taken through a two-flop synchronizer before use
  acsf_sync #(.W(1)) u_vref_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .d(vref_bad_pin),
    .q(vref_bad_sync)
  );

  acsf_conv_slice #(.RES_W(P_RES_W), .COEF_W(P_COEF_W)) u_prim (
    .sys_clk(sys_clk),
    .rst(rst),
    .ctl(p_if.conv),
    .res_valid(p_res_valid),
    .res_data(p_res_data),
    .res_clamped(p_res_clamped),
    .cal_done(p_cal_done),
    .cal_ok(p_cal_ok),
    .cal_is_gain(p_cal_is_gain),
    .cal_coef(p_cal_coef),
    .cal_block(1'b0),
    .result_ff(p_result),
    .offset_ff(p_offset),
    .gain_ff(p_gain)
  );

  acsf_conv_slice #(.RES_W(A_RES_W), .COEF_W(A_COEF_W)) u_aux (
    .sys_clk(sys_clk),
    .rst(rst),
    .ctl(a_if.conv),
    .res_valid(a_res_valid),
    .res_data(a_res_data),
    .res_clamped(a_res_clamped),
    .cal_done(a_cal_done),
    .cal_ok(a_cal_ok),
    .cal_is_gain(a_cal_is_gain),
    .cal_coef(a_cal_coef),
    .cal_block(a_temp_sel),
    .result_ff(a_result),
    .offset_ff(a_offset),
    .gain_ff(a_gain)
  );

  // ****************************************
  // byte picking
  // ****************************************
  // values are top aligned so a narrow variant loses its low byte, not its high one
  function automatic acsf_byte_t pick(input logic [MAX_W-1:0] v, input int w, input int k);
    logic [MAX_W-1:0] al;
    al = v << (MAX_W - w);
    pick = al[MAX_W-1-k*BYTE_W -: BYTE_W];
  endfunction

  logic [MAX_W-1:0] p_res_x, a_res_x, p_ofs_x, p_gn_x, a_ofs_x, a_gn_x;
  always_comb begin
    p_res_x = MAX_W'(p_result);
    a_res_x = MAX_W'(a_result);
    p_ofs_x = MAX_W'(p_offset);
    p_gn_x = MAX_W'(p_gain);
    a_ofs_x = MAX_W'(a_offset);
    a_gn_x = MAX_W'(a_gain);
  end

  // ****************************************
  // control and flags
  // ****************************************
  logic cal_ff, noref_ff;
  logic nxt_cal, nxt_noref, nxt_p_start, nxt_a_start;
  acsf_byte_t nxt_mode, nxt_decim, status_view;
  acsf_md_t wr_md;
  logic mode_wr, stat_wr, stat_bit_wr, start_any;
  logic p_rdy_clr, a_rdy_clr;

  always_comb begin
    mode_wr = sfr_wr && (sfr_addr == ADDR_MODE);
    stat_wr = sfr_wr && (sfr_addr == ADDR_STATUS);
    stat_bit_wr = bit_wr && ((bit_addr & ~8'(BIT_IDX_MASK)) == ADDR_STATUS);
    wr_md = sfr_wdata[MD_LSB +: MD_W];
    nxt_p_start = mode_wr && sfr_wdata[MODE_EN_P] && (wr_md != MD_POWER_DOWN);
    nxt_a_start = mode_wr && sfr_wdata[MODE_EN_A] && (wr_md != MD_POWER_DOWN);
    start_any = nxt_p_start || nxt_a_start;
    // writing a one leaves a ready flag alone; a zero clears it, as does a start of that converter
    p_rdy_clr = (stat_wr && !sfr_wdata[ST_RDY_P]) ||
                (stat_bit_wr && (bit_addr[2:0] == 3'(ST_RDY_P)) && !bit_wdata);
    a_rdy_clr = (stat_wr && !sfr_wdata[ST_RDY_A]) ||
                (stat_bit_wr && (bit_addr[2:0] == 3'(ST_RDY_A)) && !bit_wdata);
    nxt_mode = mode_wr ? (sfr_wdata & MODE_IMPL) : mode_ff;
    nxt_decim = (sfr_wr && (sfr_addr == ADDR_DECIM)) ? sfr_wdata : decim_ff;
    nxt_cal = p_if.cal_hit || a_if.cal_hit || (cal_ff && !start_any);
    nxt_noref = vref_bad_sync && (mode_ff[MODE_EN_P] || mode_ff[MODE_EN_A]);
  end

  assign p_if.start = nxt_p_start;
  assign a_if.start = nxt_a_start;
  assign p_if.rdy_clr = p_rdy_clr;
  assign a_if.rdy_clr = a_rdy_clr;
  assign p_if.missing_ref = noref_ff;
  assign a_if.missing_ref = noref_ff;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cal_ff <= STATUS_RST[ST_CAL];
      noref_ff <= STATUS_RST[ST_NOREF];
      mode_ff <= MODE_RST;
      decim_ff <= DECIM_INIT;
      p_start_ff <= 1'b0;
      a_start_ff <= 1'b0;
    end else begin
      cal_ff <= nxt_cal;
      noref_ff <= nxt_noref;
      mode_ff <= nxt_mode;
      decim_ff <= nxt_decim;
      p_start_ff <= nxt_p_start;
      a_start_ff <= nxt_a_start;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  acsf_byte_t nxt_rdata;
  logic nxt_bit_rdata;
  always_comb begin
    status_view = STATUS_RST;
    status_view[ST_RDY_P] = p_if.ready;
    status_view[ST_RDY_A] = a_if.ready;
    status_view[ST_CAL] = cal_ff;
    status_view[ST_NOREF] = noref_ff;
    status_view[ST_ERR_P] = p_if.err;
    status_view[ST_ERR_A] = a_if.err;
    nxt_rdata = sfr_rdata_ff;
    if (sfr_rd) begin
      unique case (sfr_addr)
        ADDR_STATUS: nxt_rdata = status_view;
        ADDR_MODE: nxt_rdata = mode_ff;
        ADDR_DECIM: nxt_rdata = decim_ff;
        ADDR_P_RES_H: nxt_rdata = pick(p_res_x, P_RES_W, 0);
        ADDR_P_RES_M: nxt_rdata = pick(p_res_x, P_RES_W, 1);
        ADDR_P_RES_L: nxt_rdata = pick(p_res_x, P_RES_W, 2);
        ADDR_A_RES_H: nxt_rdata = pick(a_res_x, A_RES_W, 0);
        ADDR_A_RES_M: nxt_rdata = pick(a_res_x, A_RES_W, 1);
        ADDR_A_RES_L: nxt_rdata = pick(a_res_x, A_RES_W, 2);
        ADDR_P_OFS_H: nxt_rdata = pick(p_ofs_x, P_COEF_W, 0);
        ADDR_P_OFS_M: nxt_rdata = pick(p_ofs_x, P_COEF_W, 1);
        ADDR_P_OFS_L: nxt_rdata = pick(p_ofs_x, P_COEF_W, 2);
        ADDR_P_GN_H: nxt_rdata = pick(p_gn_x, P_COEF_W, 0);
        ADDR_P_GN_M: nxt_rdata = pick(p_gn_x, P_COEF_W, 1);
        ADDR_P_GN_L: nxt_rdata = pick(p_gn_x, P_COEF_W, 2);
        ADDR_A_OFS_H: nxt_rdata = pick(a_ofs_x, A_COEF_W, 0);
        ADDR_A_OFS_L: nxt_rdata = pick(a_ofs_x, A_COEF_W, 1);
        ADDR_A_GN_H: nxt_rdata = pick(a_gn_x, A_COEF_W, 0);
        ADDR_A_GN_L: nxt_rdata = pick(a_gn_x, A_COEF_W, 1);
        default: nxt_rdata = STATUS_RST;
      endcase
    end
    nxt_bit_rdata = bit_rdata_ff;
    if (bit_rd) begin
      nxt_bit_rdata = ((bit_addr & ~8'(BIT_IDX_MASK)) == ADDR_STATUS) ?
                      status_view[bit_addr[2:0]] : 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sfr_rdata_ff <= STATUS_RST;
      bit_rdata_ff <= 1'b0;
    end else begin
      sfr_rdata_ff <= nxt_rdata;
      bit_rdata_ff <= nxt_bit_rdata;
    end
  end
endmodule

// File: rtl/acsf_sync.sv
`timescale 1ns/100ps
module acsf_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          meta_ff[i] <= 1'b0;
          q_ff[i] <= 1'b0;
        end else begin
          meta_ff[i] <= d[i];
          q_ff[i] <= meta_ff[i];
        end
      end
    end
  endgenerate
  assign q = q_ff;
endmodule

// File: shared/acsf_conv_if.sv
`timescale 1ns/100ps
interface acsf_conv_if;
  logic start;
  logic rdy_clr;
  logic missing_ref;
  logic ready;
  logic err;
  logic cal_hit;
  modport ctl(output start, output rdy_clr, output missing_ref,
              input ready, input err, input cal_hit);
  modport conv(input start, input rdy_clr, input missing_ref,
               output ready, output err, output cal_hit);
endinterface

// File: shared/acsf_pkg.sv
package acsf_pkg;
  // ****************************************
  // addresses
  // ****************************************
  localparam logic [7:0] ADDR_STATUS = 8'hD8;
  localparam logic [7:0] ADDR_MODE = 8'hD1;
  localparam logic [7:0] ADDR_DECIM = 8'hD2;
  localparam logic [7:0] ADDR_P_RES_L = 8'hD9;
  localparam logic [7:0] ADDR_P_RES_M = 8'hDA;
  localparam logic [7:0] ADDR_P_RES_H = 8'hDB;
  localparam logic [7:0] ADDR_A_RES_L = 8'hDC;
  localparam logic [7:0] ADDR_A_RES_M = 8'hDD;
  localparam logic [7:0] ADDR_A_RES_H = 8'hDE;
  localparam logic [7:0] ADDR_P_OFS_L = 8'hE1;
  localparam logic [7:0] ADDR_P_OFS_M = 8'hE2;
  localparam logic [7:0] ADDR_P_OFS_H = 8'hE3;
  localparam logic [7:0] ADDR_P_GN_L = 8'hE4;
  localparam logic [7:0] ADDR_P_GN_M = 8'hE5;
  localparam logic [7:0] ADDR_P_GN_H = 8'hE6;
  localparam logic [7:0] ADDR_A_OFS_L = 8'hE9;
  localparam logic [7:0] ADDR_A_OFS_H = 8'hEA;
  localparam logic [7:0] ADDR_A_GN_L = 8'hEB;
  localparam logic [7:0] ADDR_A_GN_H = 8'hEC;
  // ****************************************
  // status fields
  // ****************************************
  localparam int ST_RDY_P = 7;
  localparam int ST_RDY_A = 6;
  localparam int ST_CAL = 5;
  localparam int ST_NOREF = 4;
  localparam int ST_ERR_P = 3;
  localparam int ST_ERR_A = 2;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [2:0] BIT_IDX_MASK = 3'h7;
  // ****************************************
  // mode fields
  // ****************************************
  localparam int MODE_EN_P = 5;
  localparam int MODE_EN_A = 4;
  localparam int MD_LSB = 0;
  localparam int MD_W = 3;
  localparam logic [7:0] MODE_RST = 8'h08;
  localparam logic [7:0] MODE_IMPL = 8'h7F;
  localparam logic [2:0] MD_POWER_DOWN = 3'h0;
  localparam logic [2:0] MD_CAL_INT_ZERO = 3'h4;
  localparam logic [2:0] MD_CAL_INT_FULL = 3'h5;
  localparam logic [2:0] MD_CAL_SYS_ZERO = 3'h6;
  localparam logic [2:0] MD_CAL_SYS_FULL = 3'h7;
  localparam logic [7:0] DECIM_RST = 8'h45;
  localparam int MAX_W = 24;
  localparam int BYTE_W = 8;
  typedef logic [7:0] acsf_byte_t;
  typedef logic [MD_W-1:0] acsf_md_t;
endpackage

// File: testbench/acsf_status_chk.sv
`timescale 1ns/100ps
module acsf_status_chk
  import acsf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire acsf_pkg::acsf_byte_t sfr_wdata,
  input wire acsf_pkg::acsf_byte_t sfr_rdata_ff,
  input wire logic [7:0] bit_addr,
  input wire logic bit_rd,
  input wire logic bit_rdata_ff,
  input wire acsf_pkg::acsf_byte_t mode_ff,
  input wire acsf_pkg::acsf_byte_t decim_ff,
  input wire logic p_start_ff,
  input wire logic a_start_ff
);
  // ****
  // causes
  // ****
  wire logic mode_wr = sfr_wr && sfr_addr == ADDR_MODE;
  wire logic decim_wr = sfr_wr && sfr_addr == ADDR_DECIM;
  wire logic p_go = mode_wr && sfr_wdata[MODE_EN_P] && sfr_wdata[2:0] != 3'h0;
  wire logic a_go = mode_wr && sfr_wdata[MODE_EN_A] && sfr_wdata[2:0] != 3'h0;
  wire logic lo_bit = bit_rd && bit_addr[7:3] == ADDR_STATUS[7:3] && bit_addr[2:1] == 2'h0;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  a_mode_write: assert property (mode_wr |=> mode_ff == ($past(sfr_wdata) & MODE_IMPL))
    else $error("mode write lost");
  a_mode_hold: assert property (!mode_wr |=> $stable(mode_ff))
    else $error("mode changed alone");
  a_decim_write: assert property (decim_wr |=> decim_ff == $past(sfr_wdata))
    else $error("decim write lost");
  a_decim_hold: assert property (!decim_wr |=> $stable(decim_ff))
    else $error("decim changed alone");
  a_p_start: assert property (p_go |=> p_start_ff)
    else $error("primary start missing");
  a_p_cause: assert property (p_start_ff |-> $past(p_go))
    else $error("primary start without cause");
  a_a_start: assert property (a_go |=> a_start_ff)
    else $error("aux start missing");
  a_a_cause: assert property (a_start_ff |-> $past(a_go))
    else $error("aux start without cause");
  a_stat_unimpl: assert property (sfr_rd && sfr_addr == ADDR_STATUS |=> sfr_rdata_ff[1:0] == 2'h0)
    else $error("status low bits set");
  a_bit_unimpl: assert property (lo_bit |=> !bit_rdata_ff)
    else $error("unused bit reads one");
  a_void_read: assert property (sfr_rd && sfr_addr == 8'h00 |=> sfr_rdata_ff == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata_ff))
    else $error("read data moved");
endmodule
bind acsf_status_top acsf_status_chk chk (.sys_clk, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
  .sfr_rdata_ff, .bit_addr, .bit_rd, .bit_rdata_ff, .mode_ff, .decim_ff, .p_start_ff, .a_start_ff);

// File: testbench/tb_adc_status_flags.sv
`timescale 1ns/100ps
module tb_adc_status_flags;
  import acsf_pkg::*;
  localparam logic [1:0] RD = 2'h0, WR = 2'h1, BRD = 2'h2, BWR = 2'h3;
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic [7:0] sfr_addr = 8'h00, bit_addr = 8'h00;
  logic sfr_wr = 1'h0, sfr_rd = 1'h0, bit_wr = 1'h0, bit_rd = 1'h0, bit_wdata = 1'h0;
  logic vref_bad_pin = 1'h0, a_temp_sel = 1'h0, ev_flag = 1'h0, ev_gain = 1'h0;
  logic [3:0] evs = 4'h0;
  logic [23:0] ev_data = 24'h000000, d1, d2;
  acsf_byte_t sfr_wdata = 8'h00, sfr_rdata_ff, mode_ff, decim_ff, dv, got;
  logic bit_rdata_ff, p_start_ff, a_start_ff, rd_d = 1'h0, brd_d = 1'h0;
  logic [7:0] exp_q[$];
  string name_q[$];
  int errors = 0, checks_done = 0, seed = 17118;
  acsf_status_top dut (
    .sys_clk, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata_ff,
    .bit_addr, .bit_wr, .bit_rd, .bit_wdata, .bit_rdata_ff, .vref_bad_pin,
    .p_res_valid(evs[0]), .p_res_data(ev_data), .p_res_clamped(ev_flag),
    .p_cal_done(evs[2]), .p_cal_ok(ev_flag), .p_cal_is_gain(ev_gain), .p_cal_coef(ev_data),
    .a_res_valid(evs[1]), .a_res_data(ev_data), .a_res_clamped(ev_flag),
    .a_cal_done(evs[3]), .a_cal_ok(ev_flag), .a_cal_is_gain(ev_gain),
    .a_cal_coef(ev_data[15:0]), .a_temp_sel, .mode_ff, .decim_ff, .p_start_ff, .a_start_ff
  );
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  // ****
  // drivers
  // ****
  task automatic acc(logic [1:0] op, logic [7:0] a, logic [7:0] d, string n);
    @(posedge sys_clk);
    if (!op[0]) begin
      exp_q.push_back(d);
      name_q.push_back(n);
    end
    sfr_addr <= a;
    bit_addr <= a;
    sfr_wdata <= d;
    bit_wdata <= d[0];
    sfr_rd <= op == RD;
    sfr_wr <= op == WR;
    bit_rd <= op == BRD;
    bit_wr <= op == BWR;
    @(posedge sys_clk);
    {sfr_rd, sfr_wr, bit_rd, bit_wr} <= 4'h0;
  endtask
  // k: 0 primary result, 1 aux result, 2 primary cal, 3 aux cal
  task automatic ev(logic [1:0] k, logic [23:0] d, logic f, logic g);
    @(posedge sys_clk);
    ev_data <= d;
    ev_flag <= f;
    ev_gain <= g;
    evs <= 4'h1 << k;
    @(posedge sys_clk);
    evs <= 4'h0;
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ****
  // monitor
  // ****
  always @(posedge sys_clk) begin
    rd_d <= sfr_rd;
    brd_d <= bit_rd;
  end
  // look at negedge so the registered read data has surely landed
  always @(negedge sys_clk) begin
    if (rd_d || brd_d) begin
      got = rd_d ? sfr_rdata_ff : {7'h00, bit_rdata_ff};
      checks_done++;
      if (got !== exp_q[0]) begin
        errors++;
        $display("BAD %s expected %h seen %h", name_q[0], exp_q[0], got);
      end
      void'(exp_q.pop_front());
      void'(name_q.pop_front());
    end
  end
  initial begin
    #50000;
    errors++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'h0;
    acc(RD, ADDR_STATUS, STATUS_RST, "stat");
    acc(RD, ADDR_MODE, MODE_RST, "mode");
    acc(RD, 8'h00, 8'h00, "void");
    dv = 8'($random(seed));
    d1 = 24'($random(seed));
    d2 = ~d1;
    acc(WR, ADDR_DECIM, dv, "");
    acc(RD, ADDR_DECIM, dv, "decim");
    acc(WR, ADDR_STATUS, 8'hFF, "");
    acc(BWR, 8'hD9, 8'h01, "");
    acc(RD, ADDR_STATUS, 8'h00, "stat");
    acc(BRD, 8'hD9, 8'h00, "bit1");
    ev(2'h0, d1, 1'h0, 1'h0);
    acc(RD, ADDR_STATUS, 8'h80, "stat");
    acc(RD, ADDR_P_RES_H, d1[23:16], "res_h");
    acc(RD, ADDR_P_RES_M, d1[15:8], "res_m");
    acc(RD, ADDR_P_RES_L, d1[7:0], "res_l");
    ev(2'h0, d2, 1'h1, 1'h0);
    acc(RD, ADDR_STATUS, 8'h80, "stat");
    acc(RD, ADDR_P_RES_M, d1[15:8], "res_m");
    acc(BWR, 8'hDF, 8'h00, "");
    acc(BRD, 8'hDF, 8'h00, "bit7");
    ev(2'h1, d2, 1'h1, 1'h0);
    acc(RD, ADDR_STATUS, 8'h44, "stat");
    acc(RD, ADDR_A_RES_H, d2[23:16], "ares_h");
    ev(2'h0, d2, 1'h1, 1'h0);
    acc(RD, ADDR_STATUS, 8'hCC, "stat");
    acc(WR, ADDR_MODE, 8'h21, "");
    acc(RD, ADDR_STATUS, 8'h44, "stat");
    acc(BWR, 8'hDE, 8'h00, "");
    ev(2'h2, d1, 1'h1, 1'h1);
    acc(RD, ADDR_STATUS, 8'hA4, "stat");
    acc(RD, ADDR_P_GN_H, d1[23:16], "gn_h");
    acc(RD, ADDR_P_GN_L, d1[7:0], "gn_l");
    acc(WR, ADDR_MODE, 8'h24, "");
    acc(RD, ADDR_STATUS, 8'h04, "stat");
    ev(2'h2, d2, 1'h0, 1'h0);
    acc(BRD, 8'hDB, 8'h01, "bit3");
    acc(RD, ADDR_P_OFS_H, 8'h00, "ofs_h");
    acc(WR, ADDR_MODE, 8'h14, "");
    a_temp_sel <= 1'h1;
    ev(2'h3, d1, 1'h1, 1'h0);
    acc(RD, ADDR_STATUS, 8'h88, "stat");
    acc(RD, ADDR_A_OFS_L, 8'h00, "aofs_l");
    a_temp_sel <= 1'h0;
    acc(BWR, 8'hDF, 8'h00, "");
    acc(WR, ADDR_MODE, 8'h08, "");
    vref_bad_pin <= 1'h1;
    repeat (5) @(posedge sys_clk);
    acc(RD, ADDR_STATUS, 8'h08, "stat");
    acc(WR, ADDR_MODE, 8'h21, "");
    repeat (5) @(posedge sys_clk);
    acc(RD, ADDR_STATUS, 8'h10, "stat");
    ev(2'h0, d1, 1'h0, 1'h0);
    acc(RD, ADDR_STATUS, 8'h98, "stat");
    acc(RD, ADDR_P_RES_L, 8'hFF, "res_l");
    vref_bad_pin <= 1'h0;
    repeat (5) @(posedge sys_clk);
    acc(RD, ADDR_STATUS, 8'h88, "stat");
    for (int k = 4; k < 8; k++) begin
      acc(WR, ADDR_MODE, {5'h04, k[2:0]}, "");
      acc(RD, ADDR_MODE, {5'h04, k[2:0]}, "mode");
    end
    report_and_stop();
  end
endmodule
